// >>> pkg/fdpc_pkg.sv
// Constants shared by the switch drive and discharge protection configuration block.
package fdpc_pkg;
   // Register addresses of the two registers held here.
   localparam logic [7:0] FDPC_ADDR_FET_DRIVE = 8'h04;
   localparam logic [7:0] FDPC_ADDR_DIS_CFG = 8'h05;
   localparam logic [7:0] FDPC_RESET_VALUE = 8'h00;
   // Bit positions in the switch drive control register.
   localparam int FDPC_BIT_SLEEP = 7;
   localparam int FDPC_BIT_LDMON = 6;
   localparam int FDPC_BIT_CHG = 1;
   localparam int FDPC_BIT_DIS = 0;
   localparam logic [7:0] FDPC_FET_RW_MASK = 8'hC3;
   // Bit positions in the discharge protection configuration register.
   localparam int FDPC_BIT_OC_DISABLE = 7;
   localparam int FDPC_BIT_THR_HI = 6;
   localparam int FDPC_BIT_THR_LO = 5;
   localparam int FDPC_BIT_SC_DISABLE = 4;
   localparam int FDPC_BIT_SCT_HI = 3;
   localparam int FDPC_BIT_SCT_LO = 2;
   localparam int FDPC_BIT_TMO_HI = 1;
   localparam int FDPC_BIT_TMO_LO = 0;
   // Timeouts in microseconds for codes 00 to 11, undivided.
   localparam longint FDPC_TMO_US_0 = 160000;
   localparam longint FDPC_TMO_US_1 = 320000;
   localparam longint FDPC_TMO_US_2 = 640000;
   localparam longint FDPC_TMO_US_3 = 1280000;
   localparam longint FDPC_TIME_DIV = 64;
   localparam longint FDPC_CLK_MHZ = 100;
   localparam int FDPC_CNT_W = 28;
endpackage : fdpc_pkg

// >>> rtl/fdpc_core.sv
// Switch drive control and discharge protection configuration registers with overcurrent timing.
// Summary of operation
// RQ1 - Writing sleep bit one enters sleep, switching off both switches and regulator.
// RQ2 - Entering forced sleep clears charge, discharge and cell balance enables.
// RQ3 - Sleep bit returns to zero by hardware on wake-up.
// RQ4 - Forced sleep leaves the analog output selection unchanged.
// RQ5 - Bit 6 turns the load monitor on or off under software control.
// RQ6 - Bits 5 to 2 of the drive register are reserved, no function.
// RQ7 - Bit 1 drives the charge switch.
// RQ8 - Charge overcurrent clears charge enable unless its auto-off disable is set.
// RQ9 - Bit 0 drives the discharge switch.
// RQ10 - Discharge overcurrent or short clears discharge enable unless matching disable set.
// RQ11 - Config bit 7 set suppresses automatic turn-off on discharge overcurrent.
// RQ12 - Discharge overcurrent always sets its flag and turns on temperature supply.
// RQ13 - Config bits 6:5 select discharge overcurrent threshold 0.10V to 0.16V.
// RQ14 - Config bit 4 set suppresses automatic turn-off on short circuit.
// RQ15 - Short circuit always sets its flag and turns on temperature supply.
// RQ16 - Config bits 3:2 select short circuit threshold 0.20V to 1.20V.
// RQ17 - Config bits 1:0 select timeout 160ms to 1280ms, or 2.5ms to 20ms divided.
// RQ18 - Register contents are retained through sleep.
// RQ19 - Divider bit set divides discharge overcurrent delay by 64.
// RQ20 - Overcurrent flag set by hardware, cleared by read after condition gone.
// RQ21 - Overcurrent declared only after threshold exceeded for whole timeout.
`timescale 1ns/100ps
`default_nettype none
module fdpc_core #(
   parameter longint TMO_US_0 = fdpc_pkg::FDPC_TMO_US_0,
   parameter longint TMO_US_1 = fdpc_pkg::FDPC_TMO_US_1,
   parameter longint TMO_US_2 = fdpc_pkg::FDPC_TMO_US_2,
   parameter longint TMO_US_3 = fdpc_pkg::FDPC_TMO_US_3,
   parameter int BAL_CELLS = 7
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic status_rd,
   input wire logic wake_event,
   input wire logic discharge_time_divider,
   input wire logic [3:0] discharge_oc_level,
   input wire logic [3:0] short_level,
   input wire logic charge_oc_event,
   input wire logic charge_oc_auto_off_disable,
   input wire logic [BAL_CELLS-1:0] cell_balance_in,
   output logic [BAL_CELLS-1:0] cell_balance_enables,
   output logic charge_switch_enable,
   output logic discharge_switch_enable,
   output logic load_monitor_enable,
   output logic regulator_enable,
   output logic sleep_active,
   output logic discharge_oc_flag,
   output logic short_circuit_flag,
   output logic temp_sensor_supply_out,
   output logic [1:0] discharge_oc_threshold_sel,
   output logic [1:0] short_threshold_sel
);
   // Cycle counts from microseconds; divided values round down, none below one cycle.
   localparam longint CYC_0 = TMO_US_0 * fdpc_pkg::FDPC_CLK_MHZ;
   localparam longint CYC_1 = TMO_US_1 * fdpc_pkg::FDPC_CLK_MHZ;
   localparam longint CYC_2 = TMO_US_2 * fdpc_pkg::FDPC_CLK_MHZ;
   localparam longint CYC_3 = TMO_US_3 * fdpc_pkg::FDPC_CLK_MHZ;

   initial begin
      if (BAL_CELLS < 1 || BAL_CELLS > 7) begin
         $error("BAL_CELLS must be 1 to 7");
      end
      if (CYC_3 >= (64'h1 << fdpc_pkg::FDPC_CNT_W) || TMO_US_0 < 1) begin
         $error("Timeouts do not fit the counter");
      end
   end

   // Selects the timeout count for a code, divided when requested.
   function automatic logic [fdpc_pkg::FDPC_CNT_W-1:0] tmo_cycles(input logic [1:0] code, input logic div);
      longint c;
      c = 0;
      unique case (code)
         2'h0: c = CYC_0;
         2'h1: c = CYC_1;
         2'h2: c = CYC_2;
         2'h3: c = CYC_3;
      endcase
      if (div) begin
         c = c / fdpc_pkg::FDPC_TIME_DIV; // RQ19
      end
      if (c < 1) begin
         c = 1;
      end
      return c[fdpc_pkg::FDPC_CNT_W-1:0];
   endfunction : tmo_cycles

   logic [7:0] fet_reg;
   logic [7:0] fet_next;
   logic [7:0] cfg_reg;
   logic [7:0] cfg_next;
   logic [BAL_CELLS-1:0] bal_reg;
   logic [BAL_CELLS-1:0] bal_next;
   logic [fdpc_pkg::FDPC_CNT_W-1:0] oc_cnt_reg;
   logic [fdpc_pkg::FDPC_CNT_W-1:0] oc_cnt_next;
   logic doc_reg;
   logic doc_next;
   logic scd_reg;
   logic scd_next;
   logic tsup_reg;
   logic tsup_next;

   // Decode of the register port.
   wire wr_fet = reg_wr && (reg_addr == fdpc_pkg::FDPC_ADDR_FET_DRIVE);
   wire wr_cfg = reg_wr && (reg_addr == fdpc_pkg::FDPC_ADDR_DIS_CFG);
   wire [1:0] oc_thr_code = {cfg_reg[fdpc_pkg::FDPC_BIT_THR_HI], cfg_reg[fdpc_pkg::FDPC_BIT_THR_LO]};
   wire [1:0] sc_thr_code = {cfg_reg[fdpc_pkg::FDPC_BIT_SCT_HI], cfg_reg[fdpc_pkg::FDPC_BIT_SCT_LO]};
   wire [1:0] tmo_code = {cfg_reg[fdpc_pkg::FDPC_BIT_TMO_HI], cfg_reg[fdpc_pkg::FDPC_BIT_TMO_LO]};
   wire [fdpc_pkg::FDPC_CNT_W-1:0] tmo_limit = tmo_cycles(tmo_code, discharge_time_divider); // RQ17

   // The analog comparators deliver one-hot-ish level bits; the code picks the one that applies.
   wire oc_above = discharge_oc_level[oc_thr_code]; // RQ13
   wire sc_now = short_level[sc_thr_code]; // RQ16
   wire oc_event = oc_above && (oc_cnt_reg == tmo_limit - 1'b1); // RQ21
   wire oc_off = oc_event && !cfg_reg[fdpc_pkg::FDPC_BIT_OC_DISABLE]; // RQ11
   wire sc_off = sc_now && !cfg_reg[fdpc_pkg::FDPC_BIT_SC_DISABLE]; // RQ14
   wire chg_off = charge_oc_event && !charge_oc_auto_off_disable; // RQ8
   wire sleep_set = wr_fet && reg_wdata[fdpc_pkg::FDPC_BIT_SLEEP]; // RQ1

   // Next state of the switch drive register; hardware turn-offs win over a write.
   always_comb begin
      fet_next = fet_reg;
      bal_next = cell_balance_in;
      if (wr_fet) begin
         fet_next = reg_wdata & fdpc_pkg::FDPC_FET_RW_MASK; // RQ5 RQ6 RQ7 RQ9
      end
      if (fet_reg[fdpc_pkg::FDPC_BIT_SLEEP] && wake_event) begin
         fet_next[fdpc_pkg::FDPC_BIT_SLEEP] = 1'b0; // RQ3
      end
      if (chg_off) begin
         fet_next[fdpc_pkg::FDPC_BIT_CHG] = 1'b0; // RQ8
      end
      if (oc_off || sc_off) begin
         fet_next[fdpc_pkg::FDPC_BIT_DIS] = 1'b0; // RQ10
      end
      if (sleep_set) begin
         fet_next[fdpc_pkg::FDPC_BIT_CHG] = 1'b0; // RQ2
         fet_next[fdpc_pkg::FDPC_BIT_DIS] = 1'b0; // RQ2
      end
      // Only switch and balance enables are cleared; the analog output selection is held elsewhere, untouched.
      if (sleep_set || fet_reg[fdpc_pkg::FDPC_BIT_SLEEP]) begin
         bal_next = '0; // RQ2 RQ4
      end
   end

   // Configuration takes writes only; sleep does not touch it, so contents are retained.
   assign cfg_next = wr_cfg ? reg_wdata : cfg_reg; // RQ18

   // Overcurrent timer restarts whenever the level falls back below threshold.
   always_comb begin
      oc_cnt_next = '0;
      if (oc_above && !oc_event) begin
         oc_cnt_next = oc_cnt_reg + 1'b1; // RQ21
      end
   end

   // Status flags: set wins over the clearing read, and a read clears a flag only once its cause has gone; temp supply clears on any read without a new event.
   assign doc_next = oc_event || (doc_reg && !(status_rd && !oc_above)); // RQ12 RQ20
   assign scd_next = sc_now || (scd_reg && !(status_rd && !sc_now)); // RQ15
   assign tsup_next = oc_event || sc_now || (tsup_reg && !status_rd); // RQ12 RQ15

   // All state updates except the read data; clock enable low freezes them unless reset is high.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         fet_reg <= fdpc_pkg::FDPC_RESET_VALUE;
         cfg_reg <= fdpc_pkg::FDPC_RESET_VALUE;
         bal_reg <= '0;
         oc_cnt_reg <= '0;
         doc_reg <= 1'b0;
         scd_reg <= 1'b0;
         tsup_reg <= 1'b0;
      end else if (clk_en) begin
         fet_reg <= fet_next;
         cfg_reg <= cfg_next;
         bal_reg <= bal_next;
         oc_cnt_reg <= oc_cnt_next;
         doc_reg <= doc_next;
         scd_reg <= scd_next;
         tsup_reg <= tsup_next;
      end
   end

   // Read data is registered; unmapped addresses return zero.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         reg_rdata <= fdpc_pkg::FDPC_RESET_VALUE;
      end else if (clk_en && reg_rd) begin
         reg_rdata <= (reg_addr == fdpc_pkg::FDPC_ADDR_FET_DRIVE) ? fet_reg :
                      (reg_addr == fdpc_pkg::FDPC_ADDR_DIS_CFG) ? cfg_reg : 8'h00;
      end
   end

   // Outputs straight from flip-flops; sleep forces both switches and the regulator off.
   assign sleep_active = fet_reg[fdpc_pkg::FDPC_BIT_SLEEP];
   assign charge_switch_enable = fet_reg[fdpc_pkg::FDPC_BIT_CHG] && !sleep_active; // RQ1 RQ7
   assign discharge_switch_enable = fet_reg[fdpc_pkg::FDPC_BIT_DIS] && !sleep_active; // RQ1 RQ9
   assign regulator_enable = !sleep_active; // RQ1
   assign load_monitor_enable = fet_reg[fdpc_pkg::FDPC_BIT_LDMON]; // RQ5
   assign cell_balance_enables = bal_reg;
   assign discharge_oc_flag = doc_reg;
   assign short_circuit_flag = scd_reg;
   assign temp_sensor_supply_out = tsup_reg;
   assign discharge_oc_threshold_sel = oc_thr_code;
   assign short_threshold_sel = sc_thr_code;
endmodule : fdpc_core
`default_nettype wire

// >>> sim/fdpc_core_bench.sv
// Self-checking bench for the switch drive and discharge configuration block.
`timescale 1ns/100ps
`default_nettype none
module fdpc_core_bench;
   logic ref_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, wake_event = 1'b0, discharge_time_divider = 1'b0;
   logic charge_oc_event = 1'b0, charge_oc_auto_off_disable = 1'b0, reg_wr, reg_rd, status_rd;
   logic charge_switch_enable, discharge_switch_enable, load_monitor_enable, regulator_enable, sleep_active;
   logic discharge_oc_flag, short_circuit_flag, temp_sensor_supply_out;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, m04, m05;
   logic [3:0] discharge_oc_level = 4'h0, short_level = 4'h0;
   logic [6:0] cell_balance_in = 7'h00, cell_balance_enables;
   logic [1:0] discharge_oc_threshold_sel, short_threshold_sel;
   int err_total = 0, cmp_count = 0, cyc = 0;
   initial forever #5 ref_clk = ~ref_clk;
   fdpc_host_model host_inst (.*);
   fdpc_core #(.TMO_US_0(1), .TMO_US_1(2), .TMO_US_2(3), .TMO_US_3(4)) fdpc_core_inst (.*);
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Reference copy follows each write; a sleep write drops both switch bits.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host_inst.go(a, d, 3'b100);
      if (a == 8'h04) m04 = d & (d[7] ? 8'hC0 : 8'hC3);
      if (a == 8'h05) m05 = d;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      host_inst.go(a, 8'h00, 3'b010);
      @(negedge ref_clk);
      chk("read", exp, reg_rdata);
   endtask : rd
   task automatic outs();
      chk("pins", {sleep_active, load_monitor_enable, charge_switch_enable, discharge_switch_enable, regulator_enable,
         discharge_oc_threshold_sel, short_threshold_sel}, {m04[7:6], m04[1:0], ~m04[7], m05[6:5], m05[3:2]});
   endtask : outs
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run
   // Hang guard, far above the under two thousand cycles the run needs.
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         complete_run();
      end
   end
   initial begin
      int t;
      void'($urandom(32'h86A1FB1D));
      {m04, m05} = 16'h0000;
      repeat (2) @(negedge ref_clk);
      sys_rst = 1'b0;
      outs();
      for (int i = 0; i < 12; i++) begin
         cell_balance_in = 7'($urandom);
         wr(8'h04 + 8'(i % 3), 8'($urandom) & 8'h7F);
         rd(8'h04, m04);
         rd(8'h05, m05);
         rd(8'h06, 8'h00);
         outs();
      end
      // Forced sleep with balancing requested, then a wake-up.
      cell_balance_in = 7'h7F;
      wr(8'h05, 8'hA5);
      wr(8'h04, 8'hC3);
      @(negedge ref_clk);
      chk("balance", 16'h0000, cell_balance_enables);
      outs();
      rd(8'h04, 8'hC0);
      rd(8'h05, 8'hA5);
      wake_event = 1'b1;
      @(negedge ref_clk);
      wake_event = 1'b0;
      m04[7] = 1'b0;
      rd(8'h04, 8'h40);
      chk("balance", 16'h007F, cell_balance_enables);
      // Short and overcurrent, auto-off on and off, overcurrent on timeout codes 00 and 01 only, divider off then on.
      for (int k = 0; k < 8; k++) begin
         discharge_time_divider = k[2];
         t = (k % 4 + 1) * 100;
         if (k[2]) t = t / 64;
         wr(8'h05, {k[0], 2'b01, k[0], 2'b01, 2'(k % 4)});
         wr(8'h04, 8'h03);
         if (k[1]) short_level = 4'h2;
         else begin
            discharge_oc_level = 4'h2;
            repeat (t / 2) @(negedge ref_clk);
            discharge_oc_level = 4'h1;
            @(negedge ref_clk);
            chk("early", 16'h0000, discharge_oc_flag);
            discharge_oc_level = 4'h2;
            repeat (t - 1) @(negedge ref_clk);
            chk("timeout", 16'h0000, discharge_oc_flag);
         end
         repeat (t + 3) @(negedge ref_clk);
         chk("event", {2'b11, k[0]}, {k[1] ? short_circuit_flag : discharge_oc_flag,
            temp_sensor_supply_out, discharge_switch_enable});
         host_inst.go(8'h01, 8'h00, 3'b001);
         chk("held", 16'h0001, short_circuit_flag | discharge_oc_flag);
         {discharge_oc_level, short_level} = 8'h00;
         host_inst.go(8'h01, 8'h00, 3'b001);
         @(negedge ref_clk);
         chk("cleared", 16'h0000, short_circuit_flag | discharge_oc_flag);
      end
      for (int k = 0; k < 2; k++) begin
         wr(8'h04, 8'h03);
         charge_oc_auto_off_disable = k[0];
         charge_oc_event = 1'b1;
         @(negedge ref_clk);
         charge_oc_event = 1'b0;
         @(negedge ref_clk);
         chk("charge", k[0], charge_switch_enable);
      end
      // A drive register write while the clock enable is low must leave that register as it was.
      clk_en = 1'b0;
      host_inst.go(8'h04, 8'h42, 3'b100);
      clk_en = 1'b1;
      rd(8'h04, m04);
      // Reset again in mid-run; everything returns to its reset state.
      sys_rst = 1'b1;
      @(negedge ref_clk);
      sys_rst = 1'b0;
      {m04, m05} = 16'h0000;
      outs();
      rd(8'h05, 8'h00);
      complete_run();
   end
endmodule : fdpc_core_bench
bind fdpc_core fdpc_core_chk #(.BAL_CELLS(BAL_CELLS)) fdpc_core_chk_inst (.*);
`default_nettype wire

// >>> sim/fdpc_core_chk.sv
// Concurrent checks on the switch drive and discharge configuration block.
`timescale 1ns/100ps
`default_nettype none
module fdpc_core_chk #(parameter int BAL_CELLS = 7) (
   input wire logic ref_clk, sys_rst, clk_en, reg_wr, wake_event, charge_oc_event, charge_oc_auto_off_disable,
   input wire logic [7:0] reg_addr, reg_wdata,
   input wire logic [BAL_CELLS-1:0] cell_balance_enables,
   input wire logic charge_switch_enable, discharge_switch_enable, regulator_enable, load_monitor_enable,
   input wire logic sleep_active, discharge_oc_flag, short_circuit_flag, temp_sensor_supply_out,
   input wire logic [1:0] discharge_oc_threshold_sel, short_threshold_sel
);
   // One clock domain, so all checks share it and are muted during reset.
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   property p_sleep_off; sleep_active |-> !charge_switch_enable && !discharge_switch_enable; endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("switch on in sleep");
   property p_reg; regulator_enable == !sleep_active; endproperty
   a_reg: assert property (p_reg) else $error("regulator wrong");
   property p_bal; sleep_active |=> cell_balance_enables == '0; endproperty
   a_bal: assert property (p_bal) else $error("balance on in sleep");
   property p_wake; wake_event && clk_en |=> !sleep_active; endproperty
   a_wake: assert property (p_wake) else $error("sleep kept after wake");
   property p_ldmon; reg_wr && clk_en && reg_addr == fdpc_pkg::FDPC_ADDR_FET_DRIVE
      |=> {1'b0, load_monitor_enable, 6'h00} == ($past(reg_wdata) & 8'h40); endproperty
   a_ldmon: assert property (p_ldmon) else $error("load monitor wrong");
   property p_thr; reg_wr && clk_en && reg_addr == fdpc_pkg::FDPC_ADDR_DIS_CFG |=>
      {1'b0, discharge_oc_threshold_sel, 1'b0, short_threshold_sel, 2'b00} == ($past(reg_wdata) & 8'h6C); endproperty
   a_thr: assert property (p_thr) else $error("threshold select wrong");
   property p_temp; $rose(discharge_oc_flag) || $rose(short_circuit_flag) |-> ##[0:1] temp_sensor_supply_out; endproperty
   a_temp: assert property (p_temp) else $error("temp supply off");
   property p_chg; charge_oc_event && clk_en && !charge_oc_auto_off_disable |-> ##[1:2] !charge_switch_enable; endproperty
   a_chg: assert property (p_chg) else $error("charge switch kept");
endmodule : fdpc_core_chk
`default_nettype wire

// >>> sim/fdpc_host_model.sv
// Host side model issuing single byte register strobes.
`timescale 1ns/100ps
`default_nettype none
module fdpc_host_model (
   input wire logic ref_clk,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   output logic status_rd
);
   initial {reg_addr, reg_wdata, reg_wr, reg_rd, status_rd} = {16'h5AA5, 3'b000};
   // Released lines show the inverse byte, so a stale value never passes for a live one.
   task automatic go(input logic [7:0] a, input logic [7:0] d, input logic [2:0] s);
      @(negedge ref_clk);
      {reg_addr, reg_wdata, reg_wr, reg_rd, status_rd} = {a, d, s};
      @(negedge ref_clk);
      {reg_addr, reg_wdata, reg_wr, reg_rd, status_rd} = {~a, ~d, 3'b000};
   endtask : go
endmodule : fdpc_host_model
`default_nettype wire
